// ### psi_pkg.sv
// Package with map, field layout and identifier defaults of the status block
`default_nettype none
package psi_pkg;

   localparam int PSI_ADDR_W = 5;
   localparam int PSI_DATA_W = 16;

   // Register indices on the management port
   localparam logic [4:0] PSI_REG_STATUS   = 5'h01;
   localparam logic [4:0] PSI_REG_ID_UPPER = 5'h02;
   localparam logic [4:0] PSI_REG_ID_LOWER = 5'h03;
   localparam logic [4:0] PSI_REG_DETAIL   = 5'h11;

   // Field positions
   localparam int PSI_STAT_EXTCAP_BIT   = 0;
   localparam int PSI_STAT_JABBER_BIT   = 1;
   localparam int PSI_DETAIL_JABBER_BIT = 2;
   localparam int PSI_OUI_UP_FIRST      = 3;
   localparam int PSI_OUI_UP_LAST       = 18;
   localparam int PSI_OUI_LO_FIRST      = 19;
   localparam int PSI_OUI_LO_LAST       = 24;
   localparam int PSI_OUI_LO_TOP_POS    = 15;
   localparam int PSI_OCTET_W           = 8;
   localparam int PSI_OUI_W             = 24;
   localparam int PSI_MODEL_LSB         = 4;
   localparam int PSI_MODEL_W           = 6;
   localparam int PSI_REV_LSB           = 0;
   localparam int PSI_REV_W             = 4;

   localparam logic [15:0] PSI_ZERO_WORD = 16'h0000;

   // Identifier defaults; values are arbitrary
   localparam logic [23:0] PSI_OUI_DEFAULT   = 24'h12_3456;
   localparam logic [5:0]  PSI_MODEL_DEFAULT = 6'h05;
   localparam logic [3:0]  PSI_REV_DEFAULT   = 4'h2;

   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic [PSI_ADDR_W-1:0] addr;
      logic [PSI_DATA_W-1:0] wdata;
   } psi_mgmt_req_t;

   typedef struct packed {
      logic                  rd_valid;
      logic [PSI_DATA_W-1:0] rd_data;
   } psi_mgmt_rsp_t;

   // Serial identifier bit n (1..24): octets left to right, each lsb first
   function automatic logic psi_oui_bit(input logic [23:0] oui,
                                        input int n);
      int k;
      k = (n - 1) / PSI_OCTET_W;
      return oui[PSI_OUI_W - PSI_OCTET_W * (k + 1)
                 + (n - 1) % PSI_OCTET_W];
   endfunction

   function automatic logic [15:0] psi_id_upper(input logic [23:0] oui);
      logic [15:0] w;
      w = PSI_ZERO_WORD;
      for (int n = PSI_OUI_UP_FIRST; n <= PSI_OUI_UP_LAST; n++) begin
         w[PSI_OUI_UP_LAST - n] = psi_oui_bit(oui, n);
      end
      return w;
   endfunction

   function automatic logic [15:0] psi_id_lower(input logic [23:0] oui,
                                                input logic [5:0]  model,
                                                input logic [3:0]  rev);
      logic [15:0] w;
      w = PSI_ZERO_WORD;
      for (int n = PSI_OUI_LO_FIRST; n <= PSI_OUI_LO_LAST; n++) begin
         w[PSI_OUI_LO_TOP_POS + PSI_OUI_LO_FIRST - n] = psi_oui_bit(oui, n);
      end
      w[PSI_MODEL_LSB +: PSI_MODEL_W] = model;
      w[PSI_REV_LSB +: PSI_REV_W]     = rev;
      return w;
   endfunction

endpackage
`default_nettype wire

// ### psi_sta_model.sv
// Station management model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module psi_sta_model
   import psi_pkg::*;
(
   input  wire logic          clk,
   output var  psi_mgmt_req_t mgmt_req,
   input  wire psi_mgmt_rsp_t mgmt_rsp
);
   initial begin
      mgmt_req = '0;
   end

   // Caller raises the override enable first for identifier words
   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      mgmt_req.wr    <= 1'b1;
      mgmt_req.addr  <= a;
      mgmt_req.wdata <= d;
      @(posedge clk);
      mgmt_req.wr    <= 1'b0;
      mgmt_req.wdata <= ~d;
   endtask

   task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
      int i;
      @(posedge clk);
      mgmt_req.rd   <= 1'b1;
      mgmt_req.addr <= a;
      @(posedge clk);
      mgmt_req.rd   <= 1'b0;
      #1;
      for (i = 0; i < 4 && mgmt_rsp.rd_valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      d = (mgmt_rsp.rd_valid === 1'b1) ? mgmt_rsp.rd_data : 16'hxxxx;
   endtask
endmodule
`default_nettype wire

// ### psi_status_id_regs.sv
// Jabber and capability status bits with the two identifier registers
//
// Summary of operation
// - Inhibit bit low: detection off, flag zero
// - Inhibit high: jabber sets flag, else holds
// - One flag shown in status and detail
// - Reading either register clears flag afterwards
// - Flag latches high until a read
// - Extended capability bit always reads one
// - Two identifier words form 32-bit identifier
// - Identifier words readable at any time
// - Identifier writes need override enable set
// - Identifier octets serialised, each lsb first
// - Identifier bits 3-18 fill upper word
// - Identifier bits 19-24 at lower 15:10
// - Model number in lower word 9:4
// - Revision number in lower word 3:0
`timescale 1ns/1ns
`default_nettype none
module psi_status_id_regs
   import psi_pkg::*;
#(
   parameter logic [23:0] OUI   = PSI_OUI_DEFAULT,
   parameter logic [5:0]  MODEL = PSI_MODEL_DEFAULT,
   parameter logic [3:0]  REV   = PSI_REV_DEFAULT
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          clk_en,
   input  wire logic          jabber_event,
   input  wire logic          jabber_inhibit,
   input  wire logic          override_write_en,
   input  wire psi_mgmt_req_t mgmt_req,
   output var  psi_mgmt_rsp_t mgmt_rsp,
   output var  logic          latch_high_flag,
   output var  logic [15:0]   identifier_word_upper,
   output var  logic [15:0]   identifier_word_lower
);

   // Reset contents built from the vendor codes
   localparam logic [15:0] ID_UPPER_RST = psi_id_upper(OUI);
   localparam logic [15:0] ID_LOWER_RST =
      psi_id_lower(OUI, MODEL, REV);

   logic        jabber_flag;
   logic [15:0] identifier_upper_word;
   logic [15:0] identifier_lower_word;

   // Address decode
   wire sel_status = mgmt_req.addr == PSI_REG_STATUS;
   wire sel_detail = mgmt_req.addr == PSI_REG_DETAIL;
   wire sel_upper  = mgmt_req.addr == PSI_REG_ID_UPPER;
   wire sel_lower  = mgmt_req.addr == PSI_REG_ID_LOWER;

   wire read_clear = mgmt_req.rd & (sel_status | sel_detail);
   wire id_wr_ok   = mgmt_req.wr & override_write_en;
   wire wr_upper   = id_wr_ok & sel_upper;
   wire wr_lower   = id_wr_ok & sel_lower;

   // Register images as seen on a read
   logic [15:0] link_status_flags;
   logic [15:0] fast_detail_status;
   always_comb begin
      link_status_flags = PSI_ZERO_WORD;
      link_status_flags[PSI_STAT_EXTCAP_BIT] = 1'b1;
      link_status_flags[PSI_STAT_JABBER_BIT] = jabber_flag;
      fast_detail_status = PSI_ZERO_WORD;
      fast_detail_status[PSI_DETAIL_JABBER_BIT] = jabber_flag;
   end

   wire [15:0] read_mux =
      sel_status ? link_status_flags :
      sel_detail ? fast_detail_status :
      sel_upper  ? identifier_upper_word :
      sel_lower  ? identifier_lower_word :
      PSI_ZERO_WORD;

   // Jabber flag next value; an event beats a read clear
   logic next_jabber_flag;
   always_comb begin
      if (!jabber_inhibit) begin
         next_jabber_flag = 1'b0;
      end else if (jabber_event) begin
         next_jabber_flag = 1'b1;
      end else if (read_clear) begin
         next_jabber_flag = 1'b0;
      end else begin
         next_jabber_flag = jabber_flag;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         jabber_flag <= 1'b0;
      end else if (clk_en) begin
         jabber_flag <= next_jabber_flag;
      end
   end

   // Identifier words; bits 1 and 2 have no storage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         identifier_upper_word <= ID_UPPER_RST;
         identifier_lower_word <= ID_LOWER_RST;
      end else if (clk_en) begin
         if (wr_upper) begin
            identifier_upper_word <= mgmt_req.wdata;
         end
         if (wr_lower) begin
            identifier_lower_word <= mgmt_req.wdata;
         end
      end
   end

   // Read answer, registered; value sampled before the clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mgmt_rsp <= '0;
      end else if (clk_en) begin
         mgmt_rsp.rd_valid <= mgmt_req.rd;
         mgmt_rsp.rd_data  <= mgmt_req.rd ? read_mux : PSI_ZERO_WORD;
      end
   end

   // Mirrored outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch_high_flag       <= 1'b0;
         identifier_word_upper <= ID_UPPER_RST;
         identifier_word_lower <= ID_LOWER_RST;
      end else if (clk_en) begin
         latch_high_flag       <= next_jabber_flag;
         identifier_word_upper <= wr_upper ? mgmt_req.wdata
                                           : identifier_upper_word;
         identifier_word_lower <= wr_lower ? mgmt_req.wdata
                                           : identifier_lower_word;
      end
   end

   // Checks

   property p_inhibit_zero;
      @(posedge clk) disable iff (sys_rst)
      clk_en && !jabber_inhibit |=> !jabber_flag && !latch_high_flag;
   endproperty
   a_inhibit_zero: assert property (p_inhibit_zero)
      else $error("Jabber flag set while detection inhibited");

   property p_event_sets;
      @(posedge clk) disable iff (sys_rst)
      clk_en && jabber_inhibit && jabber_event |=> jabber_flag;
   endproperty
   a_event_sets: assert property (p_event_sets)
      else $error("Jabber event did not set the flag");

   property p_flag_holds;
      @(posedge clk) disable iff (sys_rst)
      clk_en && jabber_inhibit && !jabber_event && !mgmt_req.rd
      |=> $stable(jabber_flag);
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("Jabber flag changed without cause");

   property p_status_mirror;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd && sel_status
      |=> mgmt_rsp.rd_valid
          && mgmt_rsp.rd_data[PSI_STAT_JABBER_BIT] == $past(jabber_flag)
          && mgmt_rsp.rd_data[PSI_STAT_EXTCAP_BIT];
   endproperty
   a_status_mirror: assert property (p_status_mirror)
      else $error("Status read returned wrong jabber or capability bit");

   property p_detail_mirror;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd && sel_detail
      |=> mgmt_rsp.rd_data[PSI_DETAIL_JABBER_BIT] == $past(jabber_flag);
   endproperty
   a_detail_mirror: assert property (p_detail_mirror)
      else $error("Detail read returned wrong jabber bit");

   property p_read_clears;
      @(posedge clk) disable iff (sys_rst)
      clk_en && read_clear && !jabber_event |=> !jabber_flag;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("Status read did not clear jabber flag");

   property p_extcap_one;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd && sel_status ##1 clk_en && mgmt_req.rd
      |=> mgmt_rsp.rd_data[PSI_STAT_EXTCAP_BIT] == 1'b1 || !$past(sel_status);
   endproperty
   a_extcap_one: assert property (p_extcap_one)
      else $error("Extended capability bit read as zero");

   property p_id_read;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd && sel_upper
      |=> mgmt_rsp.rd_data == $past(identifier_upper_word);
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("Identifier read returned wrong value");

   property p_id_blocked;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.wr && !override_write_en && (sel_upper || sel_lower)
      |=> $stable(identifier_upper_word) && $stable(identifier_lower_word);
   endproperty
   a_id_blocked: assert property (p_id_blocked)
      else $error("Identifier changed without override enable");

   property p_id_written;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.wr && override_write_en && sel_lower
      |=> identifier_lower_word == $past(mgmt_req.wdata)
          && identifier_word_lower == identifier_lower_word;
   endproperty
   a_id_written: assert property (p_id_written)
      else $error("Enabled identifier write not stored");

   property p_freeze;
      @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(jabber_flag) && $stable(mgmt_rsp);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("State changed while clock enable low");

   property p_mirror_flag;
      @(posedge clk) disable iff (sys_rst)
      latch_high_flag == jabber_flag;
   endproperty
   a_mirror_flag: assert property (p_mirror_flag)
      else $error("Flag output differs from internal flag");

   property p_id_mirror;
      @(posedge clk) disable iff (sys_rst)
      identifier_word_upper == identifier_upper_word
      && identifier_word_lower == identifier_lower_word;
   endproperty
   a_id_mirror: assert property (p_id_mirror)
      else $error("Identifier outputs differ from stored words");

   property p_rd_valid_one;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd |=> mgmt_rsp.rd_valid;
   endproperty
   a_rd_valid_one: assert property (p_rd_valid_one)
      else $error("Read not answered one cycle later");

   property p_rsp_one_cycle;
      @(posedge clk) disable iff (sys_rst)
      clk_en && !mgmt_req.rd |=> !mgmt_rsp.rd_valid;
   endproperty
   a_rsp_one_cycle: assert property (p_rsp_one_cycle)
      else $error("Read answer without a read");

   property p_rd_idle_zero;
      @(posedge clk) disable iff (sys_rst)
      !mgmt_rsp.rd_valid |-> mgmt_rsp.rd_data == PSI_ZERO_WORD;
   endproperty
   a_rd_idle_zero: assert property (p_rd_idle_zero)
      else $error("Read data not zero while no answer");

   property p_id_lower_read;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd && sel_lower
      |=> mgmt_rsp.rd_data == $past(identifier_lower_word);
   endproperty
   a_id_lower_read: assert property (p_id_lower_read)
      else $error("Lower identifier read returned wrong value");

   property p_upper_write;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.wr && override_write_en && sel_upper
      |=> identifier_upper_word == $past(mgmt_req.wdata);
   endproperty
   a_upper_write: assert property (p_upper_write)
      else $error("Enabled upper identifier write not stored");

   property p_freeze_id;
      @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(identifier_upper_word)
                  && $stable(identifier_lower_word)
                  && $stable(latch_high_flag);
   endproperty
   a_freeze_id: assert property (p_freeze_id)
      else $error("Identifier or flag output changed while frozen");

   property p_set_beats_clear;
      @(posedge clk) disable iff (sys_rst)
      clk_en && jabber_inhibit && jabber_event && read_clear
      |=> jabber_flag && latch_high_flag;
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear)
      else $error("Read clear won over a jabber event");

   property p_unmapped_zero;
      @(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.rd
      && !(sel_status || sel_detail || sel_upper || sel_lower)
      |=> mgmt_rsp.rd_data == PSI_ZERO_WORD;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("Unmapped read returned nonzero data");

   c_jabber_then_read: cover property (@(posedge clk) disable iff (sys_rst)
      jabber_flag ##1 (clk_en && read_clear) ##1 !jabber_flag);
   c_set_beats_clear: cover property (@(posedge clk) disable iff (sys_rst)
      clk_en && jabber_inhibit && jabber_event && read_clear);
   c_id_write: cover property (@(posedge clk) disable iff (sys_rst)
      clk_en && wr_upper);
   c_id_blocked: cover property (@(posedge clk) disable iff (sys_rst)
      clk_en && mgmt_req.wr && !override_write_en && sel_upper);
   c_frozen_event: cover property (@(posedge clk) disable iff (sys_rst)
      !clk_en && jabber_inhibit && jabber_event);

endmodule
`default_nettype wire

// ### psi_status_id_regs_tb_top.sv
// Testbench for the jabber status and identifier registers
`timescale 1ns/1ns
`default_nettype none
module psi_status_id_regs_tb_top;
   import psi_pkg::*;
   // OUI 12_3456, model 05, rev 2 laid out by serial bit order
   localparam logic [15:0] ID_UP = 16'h20b1;
   localparam logic [15:0] ID_LO = 16'ha852;
   logic          clk;
   logic          sys_rst;
   logic          clk_en;
   logic          jabber_event;
   logic          jabber_inhibit;
   logic          override_write_en;
   psi_mgmt_req_t mgmt_req;
   psi_mgmt_rsp_t mgmt_rsp;
   logic          flag;
   logic [15:0]   id_up;
   logic [15:0]   id_lo;
   logic [15:0]   rd;
   int            fails = 0;
   int            n_checks = 0;

   psi_status_id_regs #(.OUI(24'h12_3456), .MODEL(6'h05), .REV(4'h2)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .jabber_event(jabber_event), .jabber_inhibit(jabber_inhibit),
      .override_write_en(override_write_en), .mgmt_req(mgmt_req),
      .mgmt_rsp(mgmt_rsp), .latch_high_flag(flag),
      .identifier_word_upper(id_up), .identifier_word_lower(id_lo));

   psi_sta_model u_sta (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Jabber condition as a one-cycle event
   task automatic pulse_event();
      @(posedge clk) jabber_event <= 1'b1;
      @(posedge clk) jabber_event <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   initial begin
      #100000;
      fails++;
      close_out();
   end

   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      jabber_event = 1'b0;
      jabber_inhibit = 1'b0;
      override_write_en = 1'b0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      u_sta.reg_read(PSI_REG_ID_UPPER, rd);
      check("id upper", rd, ID_UP);
      u_sta.reg_read(PSI_REG_ID_LOWER, rd);
      check("id lower", rd, ID_LO);
      check("id word upper", id_up, ID_UP);
      check("id word lower", id_lo, ID_LO);
      u_sta.reg_read(PSI_REG_STATUS, rd);
      check("status idle", rd, 16'h0001);
      $display("test reset done");
      pulse_event();
      check("flag off", {15'h0000, flag}, 16'h0000);
      u_sta.reg_read(PSI_REG_DETAIL, rd);
      check("detail off", rd, 16'h0000);
      $display("test inhibit done");
      @(posedge clk) jabber_inhibit <= 1'b1;
      clk_en <= 1'b0;
      pulse_event();
      check("flag frozen", {15'h0000, flag}, 16'h0000);
      @(posedge clk) clk_en <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         pulse_event();
         repeat (3) @(posedge clk);
         #1;
         check("flag held", {15'h0000, flag}, 16'h0001);
         u_sta.reg_read(k ? PSI_REG_DETAIL : PSI_REG_STATUS, rd);
         check("flag read", rd, k ? 16'h0004 : 16'h0003);
         check("flag cleared", {15'h0000, flag}, 16'h0000);
         u_sta.reg_read(PSI_REG_STATUS, rd);
         check("status after", rd, 16'h0001);
      end
      fork
         pulse_event();
         u_sta.reg_read(PSI_REG_STATUS, rd);
      join
      check("read with event", rd, 16'h0001);
      check("set beats clear", {15'h0000, flag}, 16'h0001);
      u_sta.reg_read(PSI_REG_DETAIL, rd);
      check("detail clears", rd, 16'h0004);
      check("flag cleared late", {15'h0000, flag}, 16'h0000);
      $display("test jabber done");
      u_sta.reg_write(PSI_REG_ID_UPPER, 16'hbeef);
      u_sta.reg_read(PSI_REG_ID_UPPER, rd);
      check("id locked", rd, ID_UP);
      @(posedge clk) override_write_en <= 1'b1;
      u_sta.reg_write(PSI_REG_ID_UPPER, 16'hbeef);
      u_sta.reg_write(PSI_REG_ID_LOWER, 16'h5aa5);
      u_sta.reg_read(PSI_REG_ID_UPPER, rd);
      check("id upper new", rd, 16'hbeef);
      u_sta.reg_read(PSI_REG_ID_LOWER, rd);
      check("id lower new", rd, 16'h5aa5);
      check("id word new", id_lo, 16'h5aa5);
      u_sta.reg_write(PSI_REG_STATUS, 16'h0000);
      u_sta.reg_read(PSI_REG_STATUS, rd);
      check("status fixed", rd, 16'h0001);
      u_sta.reg_read(5'h05, rd);
      check("unmapped", rd, 16'h0000);
      $display("test writes done");
      close_out();
   end
endmodule
`default_nettype wire
